/* hdl/map_decoder_pkg.sv */
// constants shared by the memory map decoder and its checks and bench
package map_decoder_pkg;

  // register offsets (byte addresses within the register block)
  localparam logic [9:0] RAM_BASE_OFS      = 10'h010;
  localparam logic [9:0] REG_BASE_OFS      = 10'h011;
  localparam logic [9:0] EE_BASE_OFS       = 10'h012;
  localparam logic [9:0] MISC_CTRL_OFS     = 10'h013;
  localparam logic [9:0] FLASH_WIN_LO_OFS  = 10'h0F4;
  localparam logic [9:0] FLASH_WIN_HI_OFS  = 10'h0F7;
  localparam logic [9:0] PK_DATA_OFS       = 10'h0FC;
  localparam logic [9:0] PK_DIR_OFS        = 10'h0FD;
  localparam logic [9:0] PAGE_INDEX_OFS    = 10'h0FF;
  localparam logic [9:0] PULL_CTRL_OFS     = 10'h0F0;

  // reset values
  localparam logic [7:0] RAM_BASE_RST      = 8'h20;
  localparam logic [7:0] REG_BASE_RST      = 8'h00;
  localparam logic [7:0] EE_BASE_RST       = 8'h01;
  localparam logic [7:0] MISC_CTRL_RST     = 8'h00;

  // fixed windows
  localparam logic [15:0] PAGE_WIN_LO      = 16'h8000;
  localparam logic [15:0] PAGE_WIN_HI      = 16'hBFFF;
  localparam logic [15:0] FIX6_LO          = 16'h4000;
  localparam logic [15:0] FIX6_HI          = 16'h7FFF;
  localparam logic [15:0] FIX7_LO          = 16'hC000;
  localparam logic [15:0] FIX7_HI          = 16'hFFFF;
  localparam logic [15:0] DBG_ROM_LO       = 16'hFF00;
  localparam logic [15:0] RAM_SPLIT_LAST   = 16'h0FFF;

  // field positions
  localparam int STOP_WAIT_BIT = 0;
  localparam int EE_ON_BIT     = 0;
  localparam int TESTWIN_BIT   = 7;
  localparam int PK_CSEL_BIT   = 7;
  localparam int PK_GPIO_BIT   = 3;

  // one-hot resource select codes
  typedef enum logic [6:0] {
    SEL_NONE  = 7'b000_0001,
    SEL_DBG   = 7'b000_0010,
    SEL_REG   = 7'b000_0100,
    SEL_RAM   = 7'b000_1000,
    SEL_EE    = 7'b001_0000,
    SEL_FLASH = 7'b010_0000,
    SEL_EXT   = 7'b100_0000
  } resource_t;

endpackage

/* hdl/port_k_slice.sv */
// one port k pin: data, direction, pull-up and emulation override
`timescale 1ns/10ps
`default_nettype none
module port_k_slice (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic wr_data_i,   // data register write strobe
  input  wire logic wr_dir_i,    // direction register write strobe
  input  wire logic wr_pull_i,   // pull select write strobe
  input  wire logic wdata_i,     // bit of write data
  input  wire logic emu_i,       // pin driven by emulation
  input  wire logic emu_val_i,   // emulation value
  input  wire logic pin_i,       // pin level
  output logic      data_o,      // data readback: latch when output, pin level when input
  output logic      dir_o,       // direction register value
  output logic      pull_o,      // pull-up select
  output logic      pin_o,       // pin drive value
  output logic      pin_oe_o     // pin drive enable
);

  logic data_q;  // latched output data
  logic dir_q;   // 1 = output
  logic pull_q;  // 1 = pulled up when input

  // data latch; writes while emulating land here but do not reach the pin
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_q <= 1'b0;
    end else if (wr_data_i) begin
      data_q <= wdata_i;
    end
  end

  // direction register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_q <= 1'b0;
    end else if (wr_dir_i) begin
      dir_q <= wdata_i;
    end
  end

  // pull-up select, input only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pull_q <= 1'b0;
    end else if (wr_pull_i) begin
      pull_q <= wdata_i;
    end
  end

  // pin drive registered so the top sees a flip-flop output
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o    <= emu_i ? emu_val_i : data_q;
      pin_oe_o <= emu_i | dir_q;
    end
  end

  // readback: outputs show pin latch, inputs show pin level
  assign data_o = dir_q ? data_q : pin_i;
  assign dir_o  = dir_q;
  assign pull_o = pull_q & ~dir_q;

endmodule
`default_nettype wire

/* hdl/memory_map_decoder.sv */
// memory map decoder with base relocation, program paging and port k
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module memory_map_decoder
  import map_decoder_pkg::*;
(
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     ARST_N_I,
  // mode and status straps
  input  wire logic                     SPECIAL_MODE_I,    // 1 = special mode
  input  wire logic                     EXPANDED_MODE_I,   // expanded or peripheral
  input  wire logic                     DEBUG_ACTIVE_I,    // debug rom mapped
  input  wire logic                     WAIT_MODE_I,       // cpu in wait
  input  wire logic                     PORT_K_EMU_EN_I,   // port k emulation enable
  input  wire logic                     FLASH_ENABLE_I,    // flash arrays mapped
  // core bus address for decode
  input  wire logic [15:0]              BUS_ADDR_I,
  input  wire logic                     BUS_VALID_I,
  input  wire logic                     BUS_WORD_I,        // 16-bit access
  // register port
  input  wire logic [9:0]               REG_ADDR_I,
  input  wire logic [7:0]               REG_WDATA_I,
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  output logic      [7:0]               REG_RDATA_O,
  // decode results
  output map_decoder_pkg::resource_t    RESOURCE_SEL_O,
  output logic      [1:0]               FLASH_ARRAY_O,
  output logic      [14:0]              FLASH_OFFSET_O,
  output logic      [1:0]               FLASH_REG_BLOCK_O,
  output logic                          FLASH_REG_SEL_O,
  output logic                          RAM_SPLIT_O,       // second cycle needed
  output logic                          MAP_GATED_O,
  // port k pins
  input  wire logic [7:0]               PORT_K_PIN_I,
  output logic      [7:0]               PORT_K_PIN_O,
  output logic      [7:0]               PORT_K_OE_O,
  output logic      [7:0]               PORT_K_PULL_O
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] reg_hi_q;       // register block address bits 15:11
  logic [2:0] ram_hi_q;       // ram address bits 15:13
  logic [3:0] ee_hi_q;        // eeprom address bits 15:12
  logic       stop_wait_q;    // mapping stop in wait
  logic       ee_on_q;        // eeprom map enable
  logic       testwin_q;      // flash test window enable
  logic [2:0] page_q;         // program page index
  logic       reg_lock_q;     // write-once locks
  logic       ram_lock_q;
  logic       ee_lock_q;
  logic       normal;

  assign normal = ~SPECIAL_MODE_I;

  // register block base, once in normal mode
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      reg_hi_q   <= REG_BASE_RST[7:3];
      reg_lock_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == REG_BASE_OFS) begin
      if (SPECIAL_MODE_I || !reg_lock_q) begin
        reg_hi_q <= REG_WDATA_I[7:3];
      end
      if (normal) begin
        reg_lock_q <= 1'b1;
      end
    end
  end

  // stop-in-wait: normal anytime, special never
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      stop_wait_q <= REG_BASE_RST[STOP_WAIT_BIT];
    end else if (REG_WR_I && REG_ADDR_I == REG_BASE_OFS && normal) begin
      stop_wait_q <= REG_WDATA_I[STOP_WAIT_BIT];
    end
  end

  // ram base
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ram_hi_q   <= RAM_BASE_RST[7:5];
      ram_lock_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == RAM_BASE_OFS) begin
      if (SPECIAL_MODE_I || !ram_lock_q) begin
        ram_hi_q <= REG_WDATA_I[7:5];
      end
      if (normal) begin
        ram_lock_q <= 1'b1;
      end
    end
  end

  // eeprom base; enable bit free at any time
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ee_hi_q   <= EE_BASE_RST[7:4];
      ee_on_q   <= EE_BASE_RST[EE_ON_BIT];
      ee_lock_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == EE_BASE_OFS) begin
      ee_on_q <= REG_WDATA_I[EE_ON_BIT];
      if (SPECIAL_MODE_I || !ee_lock_q) begin
        ee_hi_q <= REG_WDATA_I[7:4];
      end
      if (normal) begin
        ee_lock_q <= 1'b1;
      end
    end
  end

  // test window bit, forced clear in normal mode
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      testwin_q <= MISC_CTRL_RST[TESTWIN_BIT];
    end else if (normal) begin
      testwin_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == MISC_CTRL_OFS) begin
      testwin_q <= REG_WDATA_I[TESTWIN_BIT];
    end
  end

  // page index, writable anytime
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      page_q <= 3'h0;
    end else if (REG_WR_I && REG_ADDR_I == PAGE_INDEX_OFS) begin
      page_q <= REG_WDATA_I[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode, purely combinational from current bases
  logic       hit_dbg;
  logic       hit_reg;
  logic       hit_ram;
  logic       hit_ee;
  logic       hit_page;
  logic       hit_fix6;
  logic       hit_fix7;
  logic       hit_test;
  logic       hit_flash;
  logic       gated;
  resource_t  sel_d;
  logic [1:0] arr_d;
  logic [14:0] ofs_d;

  assign gated    = stop_wait_q & WAIT_MODE_I;
  assign hit_dbg  = DEBUG_ACTIVE_I && BUS_ADDR_I >= DBG_ROM_LO;
  // lower 1K of the 2K slot only
  assign hit_reg  = BUS_ADDR_I[15:11] == reg_hi_q && !BUS_ADDR_I[10];
  assign hit_ram  = BUS_ADDR_I[15:13] == ram_hi_q;
  // upper 2K of the 4K slot only
  assign hit_ee   = ee_on_q && BUS_ADDR_I[15:12] == ee_hi_q && BUS_ADDR_I[11];
  assign hit_test = testwin_q && SPECIAL_MODE_I && BUS_ADDR_I[15];
  assign hit_page = !testwin_q && BUS_ADDR_I >= PAGE_WIN_LO
                    && BUS_ADDR_I <= PAGE_WIN_HI;
  // low fixed half stays put: the test window only replaces 8000 upward
  assign hit_fix6 = BUS_ADDR_I >= FIX6_LO && BUS_ADDR_I <= FIX6_HI;
  assign hit_fix7 = !testwin_q && BUS_ADDR_I >= FIX7_LO && BUS_ADDR_I <= FIX7_HI;
  assign hit_flash = FLASH_ENABLE_I && (hit_page || hit_fix6 || hit_fix7 || hit_test);

  // precedence chain picks exactly one resource
  always_comb begin
    sel_d = SEL_NONE;
    if (gated) begin
      sel_d = SEL_NONE;
    end else if (hit_dbg) begin
      sel_d = SEL_DBG;
    end else if (hit_reg) begin
      sel_d = SEL_REG;
    end else if (hit_ram) begin
      sel_d = SEL_RAM;
    end else if (hit_ee) begin
      sel_d = SEL_EE;
    end else if (hit_flash) begin
      sel_d = SEL_FLASH;
    end else if (EXPANDED_MODE_I) begin
      sel_d = SEL_EXT;
    end
  end

  // array and offset inside it
  always_comb begin
    arr_d = page_q[2:1];
    ofs_d = {page_q[0], BUS_ADDR_I[13:0]};
    if (hit_test) begin
      ofs_d = BUS_ADDR_I[14:0];
    end else if (hit_fix6 || hit_fix7) begin
      arr_d = 2'h3;
      ofs_d = {BUS_ADDR_I[15], BUS_ADDR_I[13:0]};
    end
  end

  // registered decode outputs
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RESOURCE_SEL_O    <= SEL_NONE;
      FLASH_ARRAY_O     <= 2'h0;
      FLASH_OFFSET_O    <= 15'h0000;
      FLASH_REG_BLOCK_O <= 2'h0;
      FLASH_REG_SEL_O   <= 1'b0;
      RAM_SPLIT_O       <= 1'b0;
      MAP_GATED_O       <= 1'b0;
    end else begin
      RESOURCE_SEL_O    <= BUS_VALID_I ? sel_d : SEL_NONE;
      FLASH_ARRAY_O     <= arr_d;
      FLASH_OFFSET_O    <= ofs_d;
      FLASH_REG_BLOCK_O <= page_q[2:1];
      FLASH_REG_SEL_O   <= REG_ADDR_I >= FLASH_WIN_LO_OFS
                           && REG_ADDR_I <= FLASH_WIN_HI_OFS
                           && (REG_WR_I || REG_RD_I);
      // word at last byte of first 4K half needs a second cycle
      RAM_SPLIT_O       <= BUS_VALID_I && BUS_WORD_I && sel_d == SEL_RAM
                           && BUS_ADDR_I[12:0] == RAM_SPLIT_LAST[12:0];
      MAP_GATED_O       <= gated;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port k
  logic       pk_hidden;
  logic [7:0] pk_data;
  logic [7:0] pk_dir;
  logic [7:0] pk_pull;
  logic [7:0] pk_emu;
  logic [7:0] pk_emu_val;
  logic [7:0] pk_mask;
  logic       csel_q;

  // data and direction leave the map while emulating in expanded mode
  assign pk_hidden  = PORT_K_EMU_EN_I && EXPANDED_MODE_I;
  assign pk_mask    = 8'h8F;
  assign pk_emu     = PORT_K_EMU_EN_I ? 8'h87 : 8'h00;
  assign pk_emu_val = {csel_q, 4'h0, page_q};

  // select low on program space flash or external access
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      csel_q <= 1'b1;
    end else begin
      csel_q <= ~(PORT_K_EMU_EN_I && BUS_VALID_I && (hit_page || hit_test)
                 && (sel_d == SEL_FLASH || sel_d == SEL_EXT));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pk
      if (g == 4 || g == 5 || g == 6) begin : g_unused
        assign pk_data[g] = 1'b0;
        assign pk_dir[g]  = 1'b0;
        assign pk_pull[g] = 1'b0;
        always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
          if (!ARST_N_I) begin
            PORT_K_PIN_O[g]  <= 1'b0;
            PORT_K_OE_O[g]   <= 1'b0;
            PORT_K_PULL_O[g] <= 1'b0;
          end else begin
            PORT_K_PIN_O[g]  <= 1'b0;
            PORT_K_OE_O[g]   <= 1'b0;
            PORT_K_PULL_O[g] <= 1'b0;
          end
        end
      end else begin : g_pin
        logic pull_c;
        port_k_slice u_slice (
          .clk_i     (CORE_CLK_I),
          .arst_n_i  (ARST_N_I),
          .wr_data_i (REG_WR_I && !pk_hidden && REG_ADDR_I == PK_DATA_OFS),
          .wr_dir_i  (REG_WR_I && !pk_hidden && REG_ADDR_I == PK_DIR_OFS),
          .wr_pull_i (REG_WR_I && REG_ADDR_I == PULL_CTRL_OFS),
          .wdata_i   (REG_WDATA_I[g]),
          .emu_i     (pk_emu[g]),
          .emu_val_i (pk_emu_val[g]),
          .pin_i     (PORT_K_PIN_I[g]),
          .data_o    (pk_data[g]),
          .dir_o     (pk_dir[g]),
          .pull_o    (pull_c),
          .pin_o     (PORT_K_PIN_O[g]),
          .pin_oe_o  (PORT_K_OE_O[g])
        );
        assign pk_pull[g] = pull_c;
        always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
          if (!ARST_N_I) begin
            PORT_K_PULL_O[g] <= 1'b0;
          end else begin
            PORT_K_PULL_O[g] <= pull_c & ~pk_emu[g];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        REG_BASE_OFS:   REG_RDATA_O <= {reg_hi_q, 2'b00, stop_wait_q};
        RAM_BASE_OFS:   REG_RDATA_O <= {ram_hi_q, 5'h00};
        EE_BASE_OFS:    REG_RDATA_O <= {ee_hi_q, 3'h0, ee_on_q};
        MISC_CTRL_OFS:  REG_RDATA_O <= {testwin_q, 7'h00};
        PAGE_INDEX_OFS: REG_RDATA_O <= {5'h00, page_q};
        PULL_CTRL_OFS:  REG_RDATA_O <= pk_pull & pk_mask;
        PK_DATA_OFS:    REG_RDATA_O <= pk_hidden ? 8'h00 : (pk_data & pk_mask);
        PK_DIR_OFS:     REG_RDATA_O <= pk_hidden ? 8'h00 : (pk_dir & pk_mask);
        default:        REG_RDATA_O <= 8'h00;
      endcase
    end else begin
      REG_RDATA_O <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* testbench/core_bus_model.sv */
// processor core model: issues bus addresses for the decoder
`timescale 1ns/10ps
`default_nettype none
module core_bus_model (
  input  wire logic        clk_i,
  output logic      [15:0] addr_o,
  output logic             valid_o,
  output logic             word_o
);
  initial begin
    addr_o  = 16'h0000;
    valid_o = 1'b0;
    word_o  = 1'b0;
  end
  ////////////////////////////////////////
  // idle cycles model a slow core; the access is then held until the next call
  task automatic issue(input logic [15:0] a, input logic w, input int gap);
    repeat (gap) begin
      @(posedge clk_i);
      addr_o  <= ~addr_o;  // idle bus: address inverted each idle cycle, so a gap of 2 shows the stale one again
      valid_o <= 1'b0;
      word_o  <= 1'b0;
    end
    @(posedge clk_i);
    addr_o  <= a;
    valid_o <= 1'b1;
    word_o  <= w;
  endtask
endmodule
`default_nettype wire

/* testbench/memory_map_decoder_properties.sv */
// concurrent checks on the memory map decoder ports
`timescale 1ns/10ps
`default_nettype none
module memory_map_decoder_properties
  import map_decoder_pkg::*;
(
  input wire logic                       CORE_CLK_I,
  input wire logic                       ARST_N_I,
  input wire logic                       EXPANDED_MODE_I,
  input wire logic                       DEBUG_ACTIVE_I,
  input wire logic                       WAIT_MODE_I,
  input wire logic                       PORT_K_EMU_EN_I,
  input wire logic [15:0]                BUS_ADDR_I,
  input wire logic                       BUS_VALID_I,
  input wire logic                       BUS_WORD_I,
  input wire logic [9:0]                 REG_ADDR_I,
  input wire logic                       REG_WR_I,
  input wire logic                       REG_RD_I,
  input wire map_decoder_pkg::resource_t RESOURCE_SEL_O,
  input wire logic [1:0]                 FLASH_ARRAY_O,
  input wire logic [14:0]                FLASH_OFFSET_O,
  input wire logic                       FLASH_REG_SEL_O,
  input wire logic                       RAM_SPLIT_O,
  input wire logic                       MAP_GATED_O,
  input wire logic [7:0]                 PORT_K_PIN_O,
  input wire logic [7:0]                 PORT_K_OE_O,
  input wire logic [7:0]                 PORT_K_PULL_O
);
  import map_decoder_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  ////////////////////////////////////////
  // decode: a previous-cycle address explains the debug and flash selects and the split flag, the previous-cycle expanded mode the external select
  property p_onehot;
    $onehot(RESOURCE_SEL_O);
  endproperty
  a_onehot: assert property (p_onehot) else $error("select not one-hot");
  property p_dbg;
    BUS_VALID_I && DEBUG_ACTIVE_I && BUS_ADDR_I >= 16'hFF00 |=> RESOURCE_SEL_O == SEL_DBG;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug rom lost precedence");
  property p_ext;
    RESOURCE_SEL_O == SEL_EXT |-> $past(EXPANDED_MODE_I);
  endproperty
  a_ext: assert property (p_ext) else $error("external select outside expanded");
  property p_page;
    RESOURCE_SEL_O == SEL_FLASH && $past(BUS_VALID_I) && $past(BUS_ADDR_I[15:14]) == 2'b10
      |-> FLASH_OFFSET_O[13:0] == $past(BUS_ADDR_I[13:0]);
  endproperty
  a_page: assert property (p_page) else $error("window offset wrong");
  property p_fixed;
    RESOURCE_SEL_O == SEL_FLASH && $past(BUS_VALID_I) && $past(BUS_ADDR_I[15:14]) == 2'b01
      |-> FLASH_ARRAY_O == 2'd3 && !FLASH_OFFSET_O[14];
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed half not array three");
  property p_split;
    RAM_SPLIT_O |-> $past(BUS_WORD_I) && $past(BUS_ADDR_I[12:0]) == 13'h0FFF;
  endproperty
  a_split: assert property (p_split) else $error("split without word at boundary");
  ////////////////////////////////////////
  // side outputs
  property p_gate;
    MAP_GATED_O |-> $past(WAIT_MODE_I);
  endproperty
  a_gate: assert property (p_gate) else $error("gated outside wait");
  property p_pk;
    (PORT_K_PIN_O[6:4] | PORT_K_OE_O[6:4] | PORT_K_PULL_O[6:4]) == 3'b000;
  endproperty
  a_pk: assert property (p_pk) else $error("port k bits 6:4 not zero");
  // chip select lags the address by two edges
  property p_csel;
    $past(BUS_VALID_I, 2) && $past(BUS_ADDR_I[15:14], 2) == 2'b10 && $past(PORT_K_EMU_EN_I, 2)
      && $past(PORT_K_EMU_EN_I) && $past(RESOURCE_SEL_O) == SEL_FLASH |-> !PORT_K_PIN_O[7];
  endproperty
  a_csel: assert property (p_csel) else $error("chip select not low");
  property p_frs;
    FLASH_REG_SEL_O |-> $past(REG_WR_I || REG_RD_I) && $past(REG_ADDR_I[9:2]) == 8'h3D;
  endproperty
  a_frs: assert property (p_frs) else $error("flash reg select without hit");
  c_dbg: cover property (RESOURCE_SEL_O == SEL_DBG);
  c_split: cover property (RAM_SPLIT_O);
  c_frs: cover property (FLASH_REG_SEL_O);
endmodule
bind memory_map_decoder memory_map_decoder_properties u_props (
  .CORE_CLK_I, .ARST_N_I, .EXPANDED_MODE_I, .DEBUG_ACTIVE_I, .WAIT_MODE_I,
  .PORT_K_EMU_EN_I, .BUS_ADDR_I, .BUS_VALID_I, .BUS_WORD_I, .REG_ADDR_I, .REG_WR_I,
  .REG_RD_I, .RESOURCE_SEL_O, .FLASH_ARRAY_O, .FLASH_OFFSET_O, .FLASH_REG_SEL_O,
  .RAM_SPLIT_O, .MAP_GATED_O, .PORT_K_PIN_O, .PORT_K_OE_O, .PORT_K_PULL_O
);
`default_nettype wire

/* testbench/memory_map_decoder_tb_top.sv */
// self-checking bench for the memory map decoder
`timescale 1ns/10ps
`default_nettype none
module memory_map_decoder_tb_top;
  import map_decoder_pkg::*;
  logic        clk, rst_n, spc, exp_m, dbg, wt, emu, fen, valid, word, rw, rr;
  logic        fsel, split, gated;
  logic [15:0] addr;
  logic [9:0]  ra;
  logic [7:0]  wd, rd, pin_i, pin_o, oe, pull;
  logic [1:0]  farr, fblk;
  logic [14:0] foff;
  resource_t   sel;
  int          n_errors = 0;
  int          n_compared = 0;
  // reference state, starting from the reset values
  logic [7:0]  m_ram = 8'h20, m_rgb = 8'h00, m_ee = 8'h01, m_pg = 8'h00;
  logic [7:0]  m_dat = 8'h00, m_dir = 8'h00, m_pul = 8'h00;
  logic        m_stop = 1'b0, m_tw = 1'b0;
  logic [2:0]  m_lk = 3'b000;
  logic [31:0] seed = 32'd94303;

  core_bus_model core (.clk_i(clk), .addr_o(addr), .valid_o(valid), .word_o(word));
  memory_map_decoder dut (
    .CORE_CLK_I(clk), .ARST_N_I(rst_n), .SPECIAL_MODE_I(spc), .EXPANDED_MODE_I(exp_m),
    .DEBUG_ACTIVE_I(dbg), .WAIT_MODE_I(wt), .PORT_K_EMU_EN_I(emu), .FLASH_ENABLE_I(fen),
    .BUS_ADDR_I(addr), .BUS_VALID_I(valid), .BUS_WORD_I(word), .REG_ADDR_I(ra),
    .REG_WDATA_I(wd), .REG_WR_I(rw), .REG_RD_I(rr), .REG_RDATA_O(rd),
    .RESOURCE_SEL_O(sel), .FLASH_ARRAY_O(farr), .FLASH_OFFSET_O(foff),
    .FLASH_REG_BLOCK_O(fblk), .FLASH_REG_SEL_O(fsel), .RAM_SPLIT_O(split),
    .MAP_GATED_O(gated), .PORT_K_PIN_I(pin_i), .PORT_K_PIN_O(pin_o),
    .PORT_K_OE_O(oe), .PORT_K_PULL_O(pull));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // precedence walk, highest first
  function automatic resource_t m_sel(logic [15:0] a);
    if (dbg && a >= 16'hFF00) return SEL_DBG;
    if (a[15:11] == m_rgb[7:3] && !a[10]) return SEL_REG;
    if (a[15:13] == m_ram[7:5]) return SEL_RAM;
    if (m_ee[0] && a[15:12] == m_ee[7:4] && a[11]) return SEL_EE;
    if (fen && a[15:14] != 2'b00) return SEL_FLASH;
    return exp_m ? SEL_EXT : SEL_NONE;
  endfunction
  // {array, offset} of a flash hit
  function automatic logic [16:0] m_fl(logic [15:0] a);
    if (spc && m_tw && a[15]) return {m_pg[2:1], a[14:0]};
    if (a[15:14] == 2'b10) return {m_pg[2:1], m_pg[0], a[13:0]};
    return {2'b11, a[15], a[13:0]};
  endfunction
  function automatic logic [7:0] m_rd(logic [9:0] a);
    case (a)
      10'h010: return m_ram;
      10'h011: return {m_rgb[7:1], m_stop};
      10'h012: return m_ee;
      10'h0FF: return m_pg;
      10'h0FC: return (emu && exp_m) ? 8'h00 : m_dat;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  ////////////////////////////////////////
  // register port; the model follows every write
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    logic pk;
    @(posedge clk);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
    pk = !(emu && exp_m);  // hidden state as the write lands
    case (a)
      10'h010: if (spc || !m_lk[0]) m_ram = d & 8'hE0;
      10'h011: begin
        if (spc || !m_lk[1]) m_rgb = d & 8'hF8;
        if (!spc) m_stop = d[0];
      end
      10'h012: begin
        if (spc || !m_lk[2]) m_ee[7:4] = d[7:4];
        m_ee[0] = d[0];
      end
      10'h013: m_tw = spc & d[7];
      10'h0FF: m_pg = d & 8'h07;
      10'h0FC: if (pk) m_dat = d & 8'h8F;
      10'h0FD: if (pk) m_dir = d & 8'h8F;
      10'h0F0: m_pul = d & 8'h8F;
      default: ;
    endcase
    if (!spc && a >= 10'h010 && a <= 10'h012) m_lk[a[1:0]] = 1'b1;
  endtask
  task automatic reg_rd(input logic [9:0] a);
    @(posedge clk);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
    #1;
    if (a[9:2] != 8'h3D) chk("rdata", m_rd(a), rd);
    chk("flash reg sel", a[9:2] == 8'h3D, fsel);
    chk("flash reg block", m_pg[2:1], fblk);
  endtask
  // one core access, judged the cycle after it is taken
  task automatic probe(input logic [15:0] a, input logic w);
    resource_t   s;
    logic [16:0] f;
    core.issue(a, w, rnd() % 3);
    @(posedge clk);
    #1;
    s = m_sel(a);
    chk("resource", s, sel);
    if (s == SEL_FLASH) begin
      f = m_fl(a);
      chk("flash array", f[16:15], farr);
      chk("flash offset", f[14:0], foff);
    end
    chk("ram split", w && a[12:0] == 13'h0FFF && s == SEL_RAM, split);
  endtask
  // random bases, modes and addresses
  task automatic phase(input int n);
    logic [9:0]  ofs [5] = '{10'h010, 10'h011, 10'h012, 10'h013, 10'h0FF};
    logic [31:0] r;
    logic [15:0] a;
    int          k;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      k = r % 5;
      if (i % 4 == 0) begin
        reg_wr(ofs[k], r[15:8]);
        reg_rd(k == 3 ? 10'h300 : ofs[k]);
      end
      r = rnd();
      @(posedge clk);
      exp_m <= r[0];
      dbg   <= r[1];
      fen   <= r[2] | r[3];
      pin_i <= r[15:8];
      a = r[31:16];
      if (r[5:4] == 2'b00) a = {m_ram[7:5], 13'h0FFF};
      if (r[7:6] == 2'b00) a[15:8] = 8'hFF;
      probe(a, r[8]);
    end
  endtask
  ////////////////////////////////////////
  // a hang well past the few hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0; spc = 1'b1; exp_m = 1'b0; dbg = 1'b0; wt = 1'b0; emu = 1'b0;
    fen = 1'b1; ra = 10'h000; wd = 8'h00; rw = 1'b0; rr = 1'b0; pin_i = 8'h5A;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (m_lk[i]) reg_rd(10'h010 + 10'(i));
    reg_rd(10'h0FF);
    reg_rd(10'h300);
    for (int i = 0; i < 4; i++) probe(16'h0000 + 16'(i) * 16'h0400, 1'b0);
    probe(16'h3FFF, 1'b0);
    probe(16'h4000, 1'b0);
    phase(48);
    // test window in special mode
    reg_wr(10'h013, 8'h80);
    reg_wr(10'h0FF, 8'h03);
    probe(16'hC123, 1'b0);
    reg_wr(10'h013, 8'h00);
    for (int i = 0; i < 4; i++) reg_rd(10'h0F4 + 10'(i));
    // normal mode: first write locks each base
    @(posedge clk);
    spc <= 1'b0;
    reg_wr(10'h010, 8'h40);
    reg_wr(10'h010, 8'h60);
    reg_rd(10'h010);
    reg_wr(10'h011, 8'h09);
    reg_wr(10'h011, 8'h11);
    reg_rd(10'h011);
    reg_wr(10'h012, 8'h30);
    reg_wr(10'h012, 8'h50);
    reg_rd(10'h012);
    probe(16'h0800, 1'b0);
    probe(16'h3800, 1'b0);
    probe(16'h4FFF, 1'b1);
    reg_wr(10'h012, 8'h31);
    probe(16'h3800, 1'b0);
    @(posedge clk);
    wt <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("map gated", m_stop, gated);
    @(posedge clk);
    wt <= 1'b0;
    phase(32);
    // port k as plain i/o
    reg_wr(10'h0FD, 8'h8F);
    reg_wr(10'h0FC, 8'hF5);
    reg_rd(10'h0FC);
    chk("pin out", m_dat, pin_o);
    chk("pin enable", m_dir, oe);
    reg_wr(10'h0FD, 8'h0F);
    reg_wr(10'h0F0, 8'h80);
    @(posedge clk);
    #1;
    chk("pull", m_pul, pull);
    // emulation: page pins and chip select
    @(posedge clk);
    emu   <= 1'b1;
    exp_m <= 1'b0;
    fen   <= 1'b1;
    dbg   <= 1'b0;
    reg_wr(10'h0FF, 8'h05);
    reg_wr(10'h0FC, 8'hFA);
    probe(16'h8000, 1'b0);
    @(posedge clk);
    #1;
    chk("chip select", 1'b0, pin_o[7]);
    chk("page pins", m_pg[2:0], pin_o[2:0]);
    probe(16'h0800, 1'b0);
    @(posedge clk);
    #1;
    chk("chip select idle", 1'b1, pin_o[7]);
    @(posedge clk);
    exp_m <= 1'b1;
    reg_wr(10'h0FC, 8'h00);
    reg_rd(10'h0FC);
    chk("pin gpio", m_dat[3], pin_o[3]);
    wrap_up();
  end
endmodule
`default_nettype wire
